// file: ckt_pkg.sv
// Constants, register map and field layouts of the clock and tick block.
// Functional notes
// - Doubler output runs at exactly twice its input; 6-24 MHz in.
// - Doubler input from main oscillator, fast crystal or routing pin.
// - PLL reference from main oscillator, fast crystal or routing pin.
// - PLL gives 24-67 MHz; input and feedback dividers give 4032 ratios.
// - Readable lock bit set once locked, at most 250 us after enable.
// - Lock indication is routed out so it can raise an interrupt.
// - Low-speed oscillator gives 1 kHz, 33 kHz and 100 kHz clocks.
// - The 33 kHz clock is the 100 kHz clock divided by three.
// - Central tick counter is free-running, 13 bits, stepped at 1 kHz.
// - Central counter stops only in deepest sleep or debugger halt.
// - Central counter raises periodic interrupts and wakeup requests.
// - A firmware reset command clears the central counter to zero.
// - Fast tick counter is 5 bits at 100 kHz and can wake the system.
// - Fast counter restarts itself at its programmable terminal count.
// - Fast counter interrupts on each terminal count only when enabled.
// - Watch crystal feeds the seconds counter and a divider source, and gives a 1-second tick.
// - Eight digital, four analog and one bus clock 16-bit dividers.
// - CPU clock comes from a dedicated divider with a 4-bit ratio.
// - Each of the 13 selectable dividers has its own independent source selection.
// - Main oscillator offers 3, 6, 12, 24, 48 and 62 MHz.
// - In USB mode the main oscillator locks to the USB bus clock.
// - CPU divider takes its input from the divided bus clock.
// - Dividers pick one of eight sources, divide by two or more, 50% at even ratios.
package ckt_pkg;
	localparam int CLK_NS = 8;
	localparam int HCLK_MHZ = 125;
	localparam int LOCK_NS = 250000;
	localparam int LOCK_CYC = LOCK_NS / CLK_NS;
	localparam int LSO_NS = 10000;
	localparam int LSO_CYC = LSO_NS / CLK_NS;
	localparam int KHZ_DIV = 100;
	localparam int THIRD_DIV = 3;
	localparam int NDIV = 13;
	localparam int BUS_IDX = 12;
	localparam logic [7:0] A_OSC = 8'h00;
	localparam logic [7:0] A_PLL = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_TICK = 8'h0C;
	localparam logic [7:0] A_CNT = 8'h10;
	localparam logic [7:0] A_CPU = 8'h14;
	localparam logic [7:0] A_CMD = 8'h18;
	localparam logic [7:0] A_DIV = 8'h40;
	localparam logic [7:0] A_DIV_END = 8'h74;
	localparam logic [15:0] DIV_RST = 16'h0002;
	localparam logic [3:0] CPU_RST = 4'h2;
	localparam logic [14:0] SEC_LAST = 15'h7FFF;

	typedef struct packed {
		logic [1:0] dbl_src;
		logic usb_mode;
		logic dbl_en;
		logic [2:0] imo_sel;
	} ckt_osc_t;

	typedef struct packed {
		logic [5:0] q;
		logic [5:0] p;
		logic [1:0] ref_sel;
		logic en;
	} ckt_pll_t;

	typedef struct packed {
		logic fast_we;
		logic fast_ie;
		logic [4:0] fast_term;
		logic ctr_we;
		logic ctr_ie;
		logic [3:0] ctr_tap;
	} ckt_tick_t;

	localparam ckt_osc_t OSC_RST = 7'h00;
	localparam ckt_pll_t PLL_RST = 15'h0000;
	localparam ckt_tick_t TICK_RST = 13'h07C0;
endpackage : ckt_pkg

// file: ckt_clock_top.sv
// Clock sources, PLL model, tick counters and clock dividers.
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ckt_clock_top #(
	parameter int LOCK_CYC = ckt_pkg::LOCK_CYC,
	parameter int LSO_CYC = ckt_pkg::LSO_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic fast_xtal_pin,
	input wire logic dsi_pin,
	input wire logic watch_xtal_pin,
	input wire logic deep_sleep,
	input wire logic debug_halt,
	input wire logic usb_frame,
	output logic [12:0] div_clk,
	output logic cpu_clk,
	output logic dbl_strobe,
	output logic pll_strobe,
	output logic pll_lock,
	output logic low_speed_fast_clock,
	output logic low_speed_third_clock,
	output logic tick_clock_1khz,
	output logic central_irq,
	output logic central_wake,
	output logic fast_irq,
	output logic fast_wake,
	output logic second_irq
);
	// ************************************************************
	// Helper functions
	// ************************************************************
	function automatic logic [6:0] imo_mhz(input logic [2:0] s);
		unique case (s)
			3'h1: imo_mhz = 7'h06;
			3'h2: imo_mhz = 7'h0C;
			3'h3: imo_mhz = 7'h18;
			3'h4: imo_mhz = 7'h30;
			3'h5: imo_mhz = 7'h3E;
			default: imo_mhz = 7'h03;
		endcase
	endfunction : imo_mhz

	function automatic logic [15:0] eff(input logic [15:0] r);
		eff = (r < 16'h0002) ? 16'h0002 : r;
	endfunction : eff

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [5:0] pin_m, pin_s, pin_d;
	logic [5:0] rises, tgls;
	logic halt;

	// Two flops per pin; a third only feeds the edge detectors.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_m <= 6'h00;
			pin_s <= 6'h00;
			pin_d <= 6'h00;
		end else begin
			pin_m <= {usb_frame, debug_halt, deep_sleep, watch_xtal_pin,
				dsi_pin, fast_xtal_pin};
			pin_s <= pin_m;
			pin_d <= pin_s;
		end
	end
	assign rises = pin_s & ~pin_d;
	assign tgls = pin_s ^ pin_d;
	assign halt = pin_s[3] | pin_s[4];

	// ************************************************************
	// Register file and AHB-Lite slave
	// ************************************************************
	ckt_pkg::ckt_osc_t osc;
	ckt_pkg::ckt_pll_t pll;
	ckt_pkg::ckt_tick_t tick;
	logic [3:0] cpu_ratio;
	logic [15:0] div_ratio [ckt_pkg::NDIV];
	logic [2:0] div_src [ckt_pkg::NDIV];
	logic wr_pend, ctr_clr;
	logic [7:0] wr_addr;
	logic [31:0] next_rdata;
	logic [12:0] ctr_cnt;
	logic [4:0] fast_cnt;
	logic take;
	logic [7:0] ap_addr;
	logic [3:0] wr_idx;

	assign take = hsel & hready & htrans[1];
	assign ap_addr = {haddr[7:2], 2'b00};
	assign wr_idx = 4'(6'(wr_addr[7:2] - 6'h10));

	// Zero wait states: read data is captured at the address phase.
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (ap_addr)
			ckt_pkg::A_OSC: next_rdata = {25'h0, osc};
			ckt_pkg::A_PLL: next_rdata = {17'h0, pll};
			ckt_pkg::A_STAT: next_rdata = {31'h0, pll_lock};
			ckt_pkg::A_TICK: next_rdata = {19'h0, tick};
			ckt_pkg::A_CNT: next_rdata = {11'h0, fast_cnt, 3'h0, ctr_cnt};
			ckt_pkg::A_CPU: next_rdata = {28'h0, cpu_ratio};
			default: begin
				if (ap_addr >= ckt_pkg::A_DIV && ap_addr < ckt_pkg::A_DIV_END)
					next_rdata = {13'h0, div_src[4'(haddr[5:2])],
						div_ratio[4'(haddr[5:2])]};
			end
		endcase
	end

	// Bus answer flops; the slave never stretches or errors.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			hrdata <= (take & ~hwrite) ? next_rdata : 32'h0000_0000;
			wr_pend <= take & hwrite;
			if (take)
				wr_addr <= ap_addr;
		end
	end

	// Writes land in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc <= ckt_pkg::OSC_RST;
			pll <= ckt_pkg::PLL_RST;
			tick <= ckt_pkg::TICK_RST;
			cpu_ratio <= ckt_pkg::CPU_RST;
			ctr_clr <= 1'b0;
			for (int i = 0; i < ckt_pkg::NDIV; i++) begin
				div_ratio[i] <= ckt_pkg::DIV_RST;
				div_src[i] <= 3'h0;
			end
		end else begin
			ctr_clr <= wr_pend && wr_addr == ckt_pkg::A_CMD && hwdata[0];
			if (wr_pend) begin
				unique case (wr_addr)
					ckt_pkg::A_OSC: osc <= hwdata[6:0];
					ckt_pkg::A_PLL: pll <= hwdata[14:0];
					ckt_pkg::A_TICK: tick <= hwdata[12:0];
					ckt_pkg::A_CPU: cpu_ratio <= hwdata[3:0];
					default: begin
						if (wr_addr >= ckt_pkg::A_DIV
							&& wr_addr < ckt_pkg::A_DIV_END) begin
							div_ratio[wr_idx] <= hwdata[15:0];
							div_src[wr_idx] <= hwdata[18:16];
						end
					end
				endcase
			end
		end
	end

	// ************************************************************
	// Main oscillator, doubler and PLL
	// ************************************************************
	logic [7:0] imo_acc, imo_sum;
	logic imo_lvl, imo_tgl, imo_rise, dbl_sel, ref_rise;
	logic [11:0] pll_acc, pll_sum, p_eff, q_eff;
	logic [15:0] lock_cnt;

	// Edges come at twice the chosen rate, so rising edges give the rate.
	assign imo_sum = imo_acc + {osc.usb_mode ? 7'h30 : imo_mhz(osc.imo_sel),
		1'b0};

	// In USB mode the phase accumulator is realigned on every USB frame marker.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			imo_acc <= 8'h00;
			imo_lvl <= 1'b0;
			imo_tgl <= 1'b0;
			imo_rise <= 1'b0;
		end else if (osc.usb_mode && rises[5]) begin
			imo_acc <= 8'h00;
			imo_tgl <= 1'b0;
			imo_rise <= 1'b0;
		end else if (imo_sum >= 8'(ckt_pkg::HCLK_MHZ)) begin
			imo_acc <= imo_sum - 8'(ckt_pkg::HCLK_MHZ);
			imo_lvl <= ~imo_lvl;
			imo_tgl <= 1'b1;
			imo_rise <= ~imo_lvl;
		end else begin
			imo_acc <= imo_sum;
			imo_tgl <= 1'b0;
			imo_rise <= 1'b0;
		end
	end

	// Both edges of the chosen source become doubler strobes.
	always_comb begin
		unique case (osc.dbl_src)
			2'h0: dbl_sel = imo_tgl;
			2'h1: dbl_sel = tgls[0];
			2'h2: dbl_sel = tgls[1];
			default: dbl_sel = 1'b0;
		endcase
		unique case (pll.ref_sel)
			2'h0: ref_rise = imo_rise;
			2'h1: ref_rise = rises[0];
			2'h2: ref_rise = rises[1];
			default: ref_rise = 1'b0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dbl_strobe <= 1'b0;
		else
			dbl_strobe <= osc.dbl_en & dbl_sel;
	end

	property p_dbl;
		osc.dbl_en && dbl_sel |=> dbl_strobe;
	endproperty
	a_dbl: assert property (p_dbl)
		else $error("doubler strobe missing");

	// Output rate is ref times p over q plus one: 63 by 64 settings.
	assign p_eff = {6'h00, (pll.p == 6'h00) ? 6'h01 : pll.p};
	assign q_eff = 12'({6'h00, pll.q} + 12'h001);
	assign pll_sum = pll_acc + (ref_rise ? p_eff : 12'h000);

	// Lock waits for the settle time; dropping enable clears it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_acc <= 12'h000;
			pll_strobe <= 1'b0;
			lock_cnt <= 16'h0000;
			pll_lock <= 1'b0;
		end else if (!pll.en) begin
			pll_acc <= 12'h000;
			pll_strobe <= 1'b0;
			lock_cnt <= 16'h0000;
			pll_lock <= 1'b0;
		end else begin
			if (pll_sum >= q_eff) begin
				pll_acc <= pll_sum - q_eff;
				pll_strobe <= 1'b1;
			end else begin
				pll_acc <= pll_sum;
				pll_strobe <= 1'b0;
			end
			if (lock_cnt != 16'(LOCK_CYC))
				lock_cnt <= lock_cnt + 16'h0001;
			pll_lock <= lock_cnt == 16'(LOCK_CYC - 1) || pll_lock;
		end
	end

	property p_lock;
		pll_lock |-> lock_cnt == 16'(LOCK_CYC);
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock set before settle time");

	// ************************************************************
	// Low-speed oscillator and tick counters
	// ************************************************************
	logic [10:0] lso_cnt;
	logic [6:0] khz_cnt;
	logic [1:0] third_cnt;
	logic [14:0] sec_cnt;
	logic ctr_evt;
	logic [12:0] ctr_next, tap_mask;

	// The 100 kHz strobe is the base; 1 kHz and 33 kHz divide it.
	// The base period is a parameter so that short runs still see 1 kHz ticks.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lso_cnt <= 11'h000;
			khz_cnt <= 7'h00;
			third_cnt <= 2'h0;
			low_speed_fast_clock <= 1'b0;
			low_speed_third_clock <= 1'b0;
			tick_clock_1khz <= 1'b0;
		end else begin
			low_speed_fast_clock <= 1'b0;
			low_speed_third_clock <= 1'b0;
			tick_clock_1khz <= 1'b0;
			if (lso_cnt == 11'(LSO_CYC - 1)) begin
				lso_cnt <= 11'h000;
				low_speed_fast_clock <= 1'b1;
				third_cnt <= (third_cnt == 2'(ckt_pkg::THIRD_DIV - 1))
					? 2'h0 : third_cnt + 2'h1;
				low_speed_third_clock <= third_cnt
					== 2'(ckt_pkg::THIRD_DIV - 1);
				khz_cnt <= (khz_cnt == 7'(ckt_pkg::KHZ_DIV - 1))
					? 7'h00 : khz_cnt + 7'h01;
				tick_clock_1khz <= khz_cnt == 7'(ckt_pkg::KHZ_DIV - 1);
			end else begin
				lso_cnt <= lso_cnt + 11'h001;
			end
		end
	end

	property p_third;
		low_speed_third_clock |-> low_speed_fast_clock
			&& $past(third_cnt) == 2'h2;
	endproperty
	a_third: assert property (p_third)
		else $error("third clock not on every third fast tick");

	// Interrupt period is two to the power of the tap (taps above 13 act as 13), in milliseconds.
	assign tap_mask = (tick.ctr_tap > 4'hC) ? 13'h1FFF
		: 13'((13'h0001 << tick.ctr_tap) - 13'h0001);
	assign ctr_next = ctr_cnt + 13'h0001;
	assign ctr_evt = tick_clock_1khz & ~halt & ~ctr_clr
		& ((ctr_next & tap_mask) == 13'h0000);

	// A clear command beats a tick arriving in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctr_cnt <= 13'h0000;
			central_irq <= 1'b0;
			central_wake <= 1'b0;
		end else begin
			if (ctr_clr)
				ctr_cnt <= 13'h0000;
			else if (tick_clock_1khz && !halt)
				ctr_cnt <= ctr_next;
			central_irq <= ctr_evt & tick.ctr_ie;
			central_wake <= ctr_evt & tick.ctr_we;
		end
	end

	property p_ctr_step;
		!$stable(ctr_cnt) |-> ctr_cnt == 13'h0000
			|| ctr_cnt == 13'($past(ctr_cnt) + 13'h0001);
	endproperty
	a_ctr_step: assert property (p_ctr_step)
		else $error("central counter jumped");
	property p_ctr_halt;
		halt && !ctr_clr |=> $stable(ctr_cnt);
	endproperty
	a_ctr_halt: assert property (p_ctr_halt)
		else $error("central counter ran while halted");
	property p_ctr_clr;
		ctr_clr |=> ctr_cnt == 13'h0000;
	endproperty
	a_ctr_clr: assert property (p_ctr_clr)
		else $error("central counter not cleared");

	// Fast counter restarts at its terminal count.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_cnt <= 5'h00;
			fast_irq <= 1'b0;
			fast_wake <= 1'b0;
		end else begin
			fast_irq <= 1'b0;
			fast_wake <= 1'b0;
			if (low_speed_fast_clock) begin
				if (fast_cnt >= tick.fast_term) begin
					fast_cnt <= 5'h00;
					fast_irq <= tick.fast_ie;
					fast_wake <= tick.fast_we;
				end else begin
					fast_cnt <= fast_cnt + 5'h01;
				end
			end
		end
	end

	property p_fast_wrap;
		low_speed_fast_clock && fast_cnt == tick.fast_term
			|=> fast_cnt == 5'h00;
	endproperty
	a_fast_wrap: assert property (p_fast_wrap)
		else $error("fast counter missed terminal count");
	property p_fast_irq;
		fast_irq |-> $past(tick.fast_ie) && $past(low_speed_fast_clock);
	endproperty
	a_fast_irq: assert property (p_fast_irq)
		else $error("fast interrupt while disabled");

	// One second is 32768 watch crystal cycles.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_cnt <= 15'h0000;
			second_irq <= 1'b0;
		end else begin
			if (rises[2])
				sec_cnt <= sec_cnt + 15'h0001;
			second_irq <= rises[2] && sec_cnt == ckt_pkg::SEC_LAST;
		end
	end

	property p_sec;
		second_irq |-> $past(sec_cnt) == ckt_pkg::SEC_LAST;
	endproperty
	a_sec: assert property (p_sec)
		else $error("second tick off count");

	// ************************************************************
	// Clock dividers: 13 selectable ones plus the CPU divider
	// ************************************************************
	logic [7:0] src_rise;
	logic [15:0] cfg_n [14];
	logic [2:0] cfg_s [14];
	logic [15:0] act_n [14];
	logic [2:0] act_s [14];
	logic [15:0] dcnt [14];
	logic [13:0] dout, wrap, dpulse;

	assign src_rise = {rises[2], tick_clock_1khz, low_speed_fast_clock,
		dbl_strobe, pll_strobe, rises[1], rises[0], imo_rise};

	// The CPU divider counts bus divider periods.
	always_comb begin
		for (int i = 0; i < ckt_pkg::NDIV; i++) begin
			cfg_n[i] = div_ratio[i];
			cfg_s[i] = div_src[i];
			dpulse[i] = src_rise[act_s[i]];
		end
		cfg_n[13] = {12'h000, cpu_ratio};
		cfg_s[13] = 3'h0;
		dpulse[13] = wrap[ckt_pkg::BUS_IDX];
	end

	// New settings load only at a period boundary, so no runt pulses.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dout <= 14'h0000;
			wrap <= 14'h0000;
			for (int i = 0; i < 14; i++) begin
				act_n[i] <= ckt_pkg::DIV_RST;
				act_s[i] <= 3'h0;
				dcnt[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < 14; i++) begin
				wrap[i] <= 1'b0;
				if (dpulse[i]) begin
					if (dcnt[i] >= act_n[i] - 16'h0001) begin
						dcnt[i] <= 16'h0000;
						dout[i] <= 1'b1;
						wrap[i] <= 1'b1;
						act_n[i] <= eff(cfg_n[i]);
						act_s[i] <= cfg_s[i];
					end else begin
						dcnt[i] <= dcnt[i] + 16'h0001;
						dout[i] <= (dcnt[i] + 16'h0001)
							< (act_n[i] >> 1);
					end
				end
			end
		end
	end
	assign div_clk = dout[12:0];
	assign cpu_clk = dout[13];

	property p_div_cfg;
		!$stable(act_n[0]) |-> dcnt[0] == 16'h0000 && div_clk[0];
	endproperty
	a_div_cfg: assert property (p_div_cfg)
		else $error("divider ratio changed mid period");
	property p_div_min;
		act_n[13] >= 16'h0002 && dcnt[13] < act_n[13];
	endproperty
	a_div_min: assert property (p_div_min)
		else $error("divider below divide by two");
	property p_cpu_src;
		cpu_clk && !$past(cpu_clk) |-> $past(wrap[12]);
	endproperty
	a_cpu_src: assert property (p_cpu_src)
		else $error("cpu clock not stepped by bus clock");
endmodule : ckt_clock_top
`default_nettype wire

// file: ckt_pin_model.sv
// Free-running clock sources that stand outside the clock block's pins.
`timescale 1ns/1ns
`default_nettype none
module ckt_pin_model #(
	parameter int XTAL_HALF_NS = 20,
	parameter int DSI_HALF_NS = 24,
	parameter int WATCH_HALF_NS = 32
) (
	output logic fast_xtal_pin,
	output logic dsi_pin,
	output logic watch_xtal_pin
);
	// *****************************************************
	// Oscillators
	// *****************************************************

	// Crystals run free, so the pins toggle on their own from a 3 ns offset on.
	// The odd start phase keeps the edges away from the bus clock edges.
	initial begin
		fast_xtal_pin = 1'b0;
		dsi_pin = 1'b0;
		watch_xtal_pin = 1'b0;
		#3;
		fork
			forever #(XTAL_HALF_NS) fast_xtal_pin = ~fast_xtal_pin;
			forever #(DSI_HALF_NS) dsi_pin = ~dsi_pin;
			forever #(WATCH_HALF_NS) watch_xtal_pin = ~watch_xtal_pin;
		join
	end
endmodule : ckt_pin_model
`default_nettype wire

// file: clock_sources_and_timewheels_test.sv
// Self-checking bench for the clock sources and tick counters block.
`timescale 1ns/1ns
`default_nettype none
module clock_sources_and_timewheels_test;
	localparam int LOCK = 40;
	// A short low-speed period keeps the 1 kHz tick well inside the run.
	localparam int LSO = 10;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic fast_xtal_pin, dsi_pin, watch_xtal_pin;
	logic deep_sleep = 1'b0;
	logic debug_halt = 1'b0;
	logic usb_frame = 1'b0;
	logic [12:0] div_clk;
	logic cpu_clk, dbl_strobe, pll_strobe, pll_lock;
	logic lsf, lst, t1k, c_irq, c_wake, f_irq, f_wake, s_irq;
	int n_fail = 0;
	int checks = 0;
	logic [31:0] rd;
	logic [31:0] rd2;
	int n;

	// The clock toggles every half period of 8 ns.
	always #4 hclk = ~hclk;

	ckt_pin_model u_ckt_pin_model (.fast_xtal_pin(fast_xtal_pin),
		.dsi_pin(dsi_pin), .watch_xtal_pin(watch_xtal_pin));

	ckt_clock_top #(.LOCK_CYC(LOCK), .LSO_CYC(LSO)) u_ckt_clock_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .fast_xtal_pin(fast_xtal_pin), .dsi_pin(dsi_pin),
		.watch_xtal_pin(watch_xtal_pin), .deep_sleep(deep_sleep),
		.debug_halt(debug_halt), .usb_frame(usb_frame),
		.div_clk(div_clk), .cpu_clk(cpu_clk), .dbl_strobe(dbl_strobe),
		.pll_strobe(pll_strobe), .pll_lock(pll_lock),
		.low_speed_fast_clock(lsf), .low_speed_third_clock(lst),
		.tick_clock_1khz(t1k), .central_irq(c_irq),
		.central_wake(c_wake), .fast_irq(f_irq), .fast_wake(f_wake),
		.second_irq(s_irq));

	// *****************************************************
	// Bus and compare tasks
	// *****************************************************

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask : chk

	// Waits for hready at a rising edge; a stuck bus counts as a mismatch.
	task automatic wait_ready();
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && k < 50) begin
			@(posedge hclk);
			k++;
		end
		if (k >= 50) n_fail++;
	endtask : wait_ready

	task automatic ahb_xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : ahb_xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb_xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		ahb_xfer(1'b0, a, 32'h0, rd);
		chk(rd, e);
	endtask : rdchk

	function automatic logic pick(input int w);
		case (w)
			0: return lsf;
			1: return lst;
			2: return f_irq;
			3: return div_clk[0];
			4: return div_clk[1];
			5: return c_irq;
			6: return c_wake;
			7: return f_wake;
			default: return t1k;
		endcase
	endfunction : pick

	// Cycles between two rising edges of the chosen output.
	task automatic gap(input int w, output int c);
		logic p;
		int k;
		k = 0;
		p = 1'b1;
		while (!(p === 1'b0 && pick(w) === 1'b1) && k < 6000) begin
			p = pick(w);
			@(posedge hclk);
			#1;
			k++;
		end
		c = 0;
		p = 1'b1;
		while (!(p === 1'b0 && pick(w) === 1'b1) && c < 6000) begin
			p = pick(w);
			@(posedge hclk);
			#1;
			c++;
		end
	endtask : gap

	task automatic test_done();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// Cuts a hang short; the whole run needs about 12000 cycles.
	initial begin
		repeat (80000) @(posedge hclk);
		n_fail++;
		test_done();
	end

	// *****************************************************
	// Test sequence
	// *****************************************************

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, a read-only place and an unmapped word.
		rdchk(ckt_pkg::A_OSC, 32'h0);
		rdchk(ckt_pkg::A_PLL, 32'h0);
		rdchk(ckt_pkg::A_STAT, 32'h0);
		rdchk(ckt_pkg::A_TICK, 32'h000007C0);
		rdchk(ckt_pkg::A_CPU, 32'h2);
		rdchk(ckt_pkg::A_CMD, 32'h0);
		rdchk(8'h20, 32'h0);
		for (int i = 0; i < ckt_pkg::NDIV; i++)
			rdchk(ckt_pkg::A_DIV + 8'(4 * i), 32'h2);
		wr(8'h20, 32'hFFFFFFFF);
		rdchk(8'h20, 32'h0);
		wr(ckt_pkg::A_STAT, 32'h1);
		rdchk(ckt_pkg::A_STAT, 32'h0);
		wr(ckt_pkg::A_CPU, 32'hF);
		rdchk(ckt_pkg::A_CPU, 32'hF);
		wr(ckt_pkg::A_OSC, 32'h0000004D);
		rdchk(ckt_pkg::A_OSC, 32'h0000004D);
		// One doubler strobe per edge of the 24 ns routing pin: 16 in 48.
		n = 0;
		repeat (48) begin
			@(posedge hclk);
			#1;
			if (dbl_strobe === 1'b1) n++;
		end
		chk(32'(n), 32'd16);
		// All six main oscillator selections are accepted.
		for (int i = 0; i < 6; i++) begin
			wr(ckt_pkg::A_OSC, 32'(i));
			rdchk(ckt_pkg::A_OSC, 32'(i));
		end
		wr(ckt_pkg::A_OSC, 32'h00000010);
		usb_frame <= 1'b1;
		repeat (4) @(posedge hclk);
		usb_frame <= 1'b0;
		rdchk(ckt_pkg::A_OSC, 32'h10);
		// Lock comes a fixed count after enable and drops when disabled.
		wr(ckt_pkg::A_PLL, 32'h00007FFD);
		n = 0;
		while (pll_lock !== 1'b1 && n < 200) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk(32'(n >= LOCK && n <= LOCK + 2), 32'h1);
		rdchk(ckt_pkg::A_STAT, 32'h1);
		rdchk(ckt_pkg::A_PLL, 32'h00007FFD);
		wr(ckt_pkg::A_PLL, 32'h0);
		@(posedge hclk);
		#1;
		chk({31'h0, pll_lock}, 32'h0);
		deep_sleep <= 1'b1;
		debug_halt <= 1'b1;
		repeat (20) @(posedge hclk);
		deep_sleep <= 1'b0;
		debug_halt <= 1'b0;
		// Low-speed clocks: one base period apart, and every third of those.
		gap(0, n);
		chk(32'(n), 32'(LSO));
		gap(1, n);
		chk(32'(n), 32'(3 * LSO));
		// Fast counter wraps at terminal 1, interrupt every second tick.
		wr(ckt_pkg::A_TICK, 32'h00001840);
		gap(2, n);
		chk(32'(n), 32'(2 * LSO));
		gap(7, n);
		chk(32'(n), 32'(2 * LSO));
		ahb_xfer(1'b0, ckt_pkg::A_CNT, 32'h0, rd);
		chk(32'(rd[20:16] <= 5'd1), 32'h1);
		wr(ckt_pkg::A_TICK, 32'h00000040);
		n = 0;
		repeat (3000) begin
			@(posedge hclk);
			#1;
			if (f_irq === 1'b1) n++;
		end
		chk(32'(n), 32'h0);
		// A halt freezes the central count across a tick; clear still works.
		debug_halt <= 1'b1;
		repeat (4) @(posedge hclk);
		ahb_xfer(1'b0, ckt_pkg::A_CNT, 32'h0, rd);
		repeat (ckt_pkg::KHZ_DIV * LSO + 200) @(posedge hclk);
		ahb_xfer(1'b0, ckt_pkg::A_CNT, 32'h0, rd2);
		chk({19'h0, rd2[12:0]}, {19'h0, rd[12:0]});
		chk(32'(rd[12:0] != 13'h0000), 32'h1);
		wr(ckt_pkg::A_CMD, 32'h1);
		ahb_xfer(1'b0, ckt_pkg::A_CNT, 32'h0, rd2);
		chk({19'h0, rd2[12:0]}, 32'h0);
		debug_halt <= 1'b0;
		// Tap 1 with interrupt and wakeup on: a pulse every second tick.
		wr(ckt_pkg::A_TICK, 32'h00000031);
		gap(8, n);
		chk(32'(n), 32'(ckt_pkg::KHZ_DIV * LSO));
		gap(5, n);
		chk(32'(n), 32'(2 * ckt_pkg::KHZ_DIV * LSO));
		gap(6, n);
		chk(32'(n), 32'(2 * ckt_pkg::KHZ_DIV * LSO));
		// Two dividers on their own sources: fast crystal and routing pin.
		wr(ckt_pkg::A_DIV, 32'h00010004);
		wr(ckt_pkg::A_DIV + 8'h04, 32'h00020000);
		rdchk(ckt_pkg::A_DIV, 32'h00010004);
		gap(3, n);
		gap(3, n);
		chk(32'(n), 32'd20);
		gap(4, n);
		gap(4, n);
		chk(32'(n), 32'd12);
		test_done();
	end
endmodule : clock_sources_and_timewheels_test
`default_nettype wire
